// file: rtl/slc_status_ctrl.sv
// Functional notes
// R01: Latched VCXO lock-loss reads 0 after any loss event since clear, else 1.
// R02: Writing 1 clears the VCXO lock-loss latch and its pending interrupt.
// R03: Each input has a latched loss-of-signal bit reading 0 after any event.
// R04: Writing 1 clears an input's loss-of-signal latch and its interrupt.
// R05: Two-bit read-only field shows the currently selected reference input.
// R06: Live synthesizer lock bit reads 0 on loss of lock; feeds its latch.
// R07: Live VCXO lock bit reads 0 on loss of lock; feeds its latch.
// R08: Live activity bit per input reads 0 on loss of signal, 1 active.
// R09: Latched reference-valid reads 0 if reference was lost since clear.
// R10: Writing 1 clears the reference-valid latch and its interrupt.
// R11: Latched holdover reads 0 if holdover was entered since clear.
// R12: Writing 1 clears the holdover latch with its pending interrupt.
// R13: Calibration bit reads 1 while synthesizer calibration runs, 0 when done.
// R14: Live reference-present bit reads 1 when a reference is present.
// R15: Live holdover bit reads 0 in holdover, 1 when locked or locking.
// R16: Writing 1 to divider-init command pulses divider initialization once.
// R17: Writing 1 to synth_lock_restart_cmd command forces synthesizer lock acquisition again.
// R18: Bias calibration command starts calibration and clears only when done.
// R19: Readback edge bit picks falling (0) or rising (1) serial data edge.
// R20: Enabled set latch drives the active-low interrupt output low.
// R21: Any change of reference validity raises the interrupt when enabled.
// R22: Interrupt returns high once all enabled pending latches are cleared.
`timescale 1ns/100ps
module slc_status_ctrl
	import slc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic csN,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	input wire logic synthLockLive,
	input wire logic vcxoLockLive,
	input wire logic [N_INPUTS-1:0] inputActiveLive,
	input wire logic [1:0] selectedInputCode,
	input wire logic refPresentLive,
	input wire logic holdoverLive,
	input wire logic synthCalBusy,
	input wire logic biasTrimDone,
	output logic dividerInitPulse,
	output logic synthLockRestartCmd,
	output logic biasTrimCmd,
	output logic readbackEdgeSelect,
	output logic irqOutN
);

	logic sclkPrev;
	logic sclkRise;
	logic sclkFall;
	logic [4:0] bitCnt;
	logic [DATA_W-1:0] inShift;
	logic [DATA_W-1:0] outShift;
	logic isRead;
	logic [ADDR_W-1:0] regAddr;
	logic hdrDone;
	logic regWrite;
	logic [DATA_W-1:0] wrData;
	logic [ADDR_W-1:0] hdrAddr;
	logic [DATA_W-1:0] readVal;
	logic driveEdge;
	logic driveWindow;

	logic [N_INPUTS-1:0] losSeen;
	logic [N_INPUTS-1:0] losNow;
	logic vcxoSeen;
	logic synthSeen;
	logic holdSeen;
	logic refLost;
	logic refChangePend;
	logic refPresentPrev;
	logic [N_INPUTS-1:0] losIrqEn;
	logic vcxoIrqEn;
	logic synthIrqEn;
	logic refIrqEn;
	logic holdIrqEn;
	logic wrLatchA;
	logic wrLatchB;
	logic next_irqOutN;

	// Serial pins are synchronous to clk; edges are found by comparing samples
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclkPrev <= 1'b0;
		end else begin
			sclkPrev <= sclk;
		end
	end

	assign sclkRise = sclk & ~sclkPrev;
	assign sclkFall = ~sclk & sclkPrev;
	assign hdrDone = sclkRise && !csN && (bitCnt == HDR_LAST);
	assign hdrAddr = {inShift[ADDR_W-2:0], serialDataIn};
	assign regWrite = sclkRise && !csN && (bitCnt == FRAME_LAST) && !isRead;
	assign wrData = {inShift[DATA_W-2:0], serialDataIn};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bitCnt <= 5'h00;
			inShift <= DATA_ZERO;
			isRead <= 1'b0;
			regAddr <= '0;
		end else if (csN) begin
			bitCnt <= 5'h00;
		end else if (sclkRise && bitCnt != FRAME_DONE) begin
			inShift <= wrData;
			bitCnt <= bitCnt + CNT_STEP;
			if (bitCnt == HDR_LAST) begin
				isRead <= inShift[HDR_RW_POS];
				regAddr <= hdrAddr;
			end
		end
	end

	// Read mux, indexed by the address just completed in the header
	always_comb begin
		readVal = DATA_ZERO;
		unique case (hdrAddr)
			ADDR_IRQ_EN_A: begin
				readVal = {2'b00, synthIrqEn, vcxoIrqEn, losIrqEn};
			end
			ADDR_IRQ_EN_B: begin
				readVal = {6'b000000, refIrqEn, holdIrqEn};
			end
			ADDR_LATCH_A: begin
				readVal = {2'b00, ~synthSeen, ~vcxoSeen, ~losSeen}; // see R01 see R03
			end
			ADDR_LIVE_A: begin
				// see R05 see R06 see R07 see R08
				readVal = {selectedInputCode, synthLockLive, vcxoLockLive, inputActiveLive};
			end
			ADDR_LATCH_B: begin
				readVal = {6'b000000, ~refLost, ~holdSeen}; // see R09 see R11
			end
			ADDR_LIVE_B: begin
				// see R13 see R14 see R15
				readVal = {5'b00000, synthCalBusy, refPresentLive, holdoverLive};
			end
			ADDR_BIAS_EDGE: begin
				// Command bit reads back as busy until calibration ends
				readVal = {biasTrimCmd, 6'b000000, readbackEdgeSelect};
			end
			default: begin
				readVal = DATA_ZERO;
			end
		endcase
	end

	assign driveEdge = readbackEdgeSelect ? sclkRise : sclkFall; // see R19
	assign driveWindow = isRead && (bitCnt >= DATA_FIRST) && (bitCnt <= FRAME_LAST);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			serialDataOut <= 1'b0;
			serialDataOe <= 1'b0;
			outShift <= DATA_ZERO;
		end else if (csN) begin
			serialDataOut <= 1'b0;
			serialDataOe <= 1'b0;
		end else if (hdrDone && inShift[HDR_RW_POS]) begin
			// Rising-edge mode must present the first bit on the header's last edge
			if (readbackEdgeSelect) begin
				serialDataOut <= readVal[DATA_W-1];
				outShift <= {readVal[DATA_W-2:0], 1'b0};
				serialDataOe <= 1'b1;
			end else begin
				outShift <= readVal;
			end
		end else if (driveWindow && driveEdge) begin
			serialDataOut <= outShift[DATA_W-1]; // see R19
			outShift <= {outShift[DATA_W-2:0], 1'b0};
			serialDataOe <= 1'b1;
		end
	end

	assign wrLatchA = regWrite && (regAddr == ADDR_LATCH_A);
	assign wrLatchB = regWrite && (regAddr == ADDR_LATCH_B);
	assign losNow = ~inputActiveLive;

	genvar gi;
	generate
		for (gi = 0; gi < N_INPUTS; gi++) begin : g_los
			slc_sticky_flag uLos ( // see R03 see R04
				.clk(clk),
				.rstn(rstn),
				.setEvent(losNow[gi]),
				.clearReq(wrLatchA && wrData[gi]),
				.flag(losSeen[gi])
			);
		end
	endgenerate

	slc_sticky_flag uVcxo ( // see R01 see R02
		.clk(clk),
		.rstn(rstn),
		.setEvent(!vcxoLockLive),
		.clearReq(wrLatchA && wrData[BIT_VCXO]),
		.flag(vcxoSeen)
	);

	slc_sticky_flag uSynth ( // see R06
		.clk(clk),
		.rstn(rstn),
		.setEvent(!synthLockLive),
		.clearReq(wrLatchA && wrData[BIT_SYNTH]),
		.flag(synthSeen)
	);

	slc_sticky_flag uHold ( // see R11 see R12
		.clk(clk),
		.rstn(rstn),
		.setEvent(!holdoverLive),
		.clearReq(wrLatchB && wrData[BIT_HOLD]),
		.flag(holdSeen)
	);

	slc_sticky_flag uRefLost ( // see R09 see R10
		.clk(clk),
		.rstn(rstn),
		.setEvent(!refPresentLive),
		.clearReq(wrLatchB && wrData[BIT_REF]),
		.flag(refLost)
	);

	// Reference interrupt tracks any change, loss or return
	slc_sticky_flag uRefChange ( // see R21 see R10
		.clk(clk),
		.rstn(rstn),
		.setEvent(refPresentLive != refPresentPrev),
		.clearReq(wrLatchB && wrData[BIT_REF]),
		.flag(refChangePend)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			refPresentPrev <= 1'b0;
		end else begin
			refPresentPrev <= refPresentLive;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			losIrqEn <= '0;
			vcxoIrqEn <= 1'b0;
			synthIrqEn <= 1'b0;
			refIrqEn <= 1'b0;
			holdIrqEn <= 1'b0;
		end else if (regWrite && regAddr == ADDR_IRQ_EN_A) begin
			losIrqEn <= wrData[N_INPUTS-1:0];
			vcxoIrqEn <= wrData[BIT_VCXO];
			synthIrqEn <= wrData[BIT_SYNTH];
		end else if (regWrite && regAddr == ADDR_IRQ_EN_B) begin
			refIrqEn <= wrData[BIT_REF];
			holdIrqEn <= wrData[BIT_HOLD];
		end
	end

	assign next_irqOutN = ~(|(losSeen & losIrqEn) | (vcxoSeen & vcxoIrqEn)
		| (synthSeen & synthIrqEn) | (refChangePend & refIrqEn) | (holdSeen & holdIrqEn));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqOutN <= 1'b1;
		end else begin
			irqOutN <= next_irqOutN; // see R20 see R22
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dividerInitPulse <= 1'b0;
			synthLockRestartCmd <= 1'b0;
		end else begin
			// see R16
			dividerInitPulse <= regWrite && regAddr == ADDR_DIV_INIT && wrData[BIT_CMD];
			// see R17
			synthLockRestartCmd <= regWrite && regAddr == ADDR_SYNTH_LOCK_RESTART_CMD && wrData[BIT_CMD];
		end
	end

	// Calibrator holds off the clear; a fresh start request beats a done
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			biasTrimCmd <= 1'b0;
			readbackEdgeSelect <= EDGE_RESET;
		end else if (regWrite && regAddr == ADDR_BIAS_EDGE) begin
			if (wrData[BIT_CMD]) begin
				biasTrimCmd <= 1'b1; // see R18
			end else if (biasTrimDone) begin
				biasTrimCmd <= 1'b0;
			end
			readbackEdgeSelect <= wrData[BIT_EDGE]; // see R19
		end else if (biasTrimDone) begin
			biasTrimCmd <= 1'b0; // see R18
		end
	end

	vcxo_latch_a: assert property (@(posedge clk) disable iff (!rstn) // see R01
		!vcxoLockLive |=> vcxoSeen ##1 (vcxoSeen || $past(wrLatchA)))
		else $error("VCXO lock loss not latched");

	los_latch_a: assert property (@(posedge clk) disable iff (!rstn) // see R03
		(losNow != '0) |=> ((losSeen & $past(losNow)) == $past(losNow)))
		else $error("Input loss of signal not latched");

	vcxo_clear_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
		(wrLatchA && wrData[BIT_VCXO] && vcxoLockLive) |=> !vcxoSeen ##2 irqOutN || !vcxoIrqEn
		|| $past(regWrite) || !next_irqOutN)
		else $error("VCXO latch clear failed");

	irq_assert_a: assert property (@(posedge clk) disable iff (!rstn) // see R20
		(vcxoSeen && vcxoIrqEn) |=> !irqOutN)
		else $error("Enabled latch did not pull interrupt low");

	irq_release_a: assert property (@(posedge clk) disable iff (!rstn) // see R22
		$rose(irqOutN) |-> $past(regWrite, 2))
		else $error("Interrupt released without a register write");

	ref_change_a: assert property (@(posedge clk) disable iff (!rstn) // see R21
		(refPresentLive != refPresentPrev) |=> refChangePend)
		else $error("Reference change not recorded");

	synth_lock_restart_cmd_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // see R17
		(regWrite && regAddr == ADDR_SYNTH_LOCK_RESTART_CMD && wrData[BIT_CMD])
		|=> synthLockRestartCmd ##1 !synthLockRestartCmd)
		else $error("Synth_lock_restart_cmd command not a single pulse");

	bias_hold_a: assert property (@(posedge clk) disable iff (!rstn) // see R18
		(biasTrimCmd && !biasTrimDone) |=> biasTrimCmd)
		else $error("Bias calibration command dropped early");

	read_edge_a: assert property (@(posedge clk) disable iff (!rstn) // see R19
		$changed(serialDataOut) |-> ($past(driveEdge) || $past(csN)))
		else $error("Read data changed off the selected edge");

endmodule

// file: rtl/slc_pkg.sv
package slc_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int N_INPUTS = 4;

	// Serial frame: read flag, seven address bits, eight data bits
	localparam logic [4:0] HDR_LAST = 5'h07;
	localparam logic [4:0] DATA_FIRST = 5'h08;
	localparam logic [4:0] FRAME_LAST = 5'h0F;
	localparam logic [4:0] FRAME_DONE = 5'h10;
	localparam logic [4:0] CNT_STEP = 5'h01;
	localparam int HDR_RW_POS = 6;

	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN_A = 7'h68;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN_B = 7'h69;
	localparam logic [ADDR_W-1:0] ADDR_LATCH_A = 7'h6C;
	localparam logic [ADDR_W-1:0] ADDR_LIVE_A = 7'h6D;
	localparam logic [ADDR_W-1:0] ADDR_LATCH_B = 7'h6E;
	localparam logic [ADDR_W-1:0] ADDR_LIVE_B = 7'h6F;
	localparam logic [ADDR_W-1:0] ADDR_DIV_INIT = 7'h71;
	localparam logic [ADDR_W-1:0] ADDR_SYNTH_LOCK_RESTART_CMD = 7'h72;
	localparam logic [ADDR_W-1:0] ADDR_BIAS_EDGE = 7'h73;

	// Field positions
	localparam int BIT_SYNTH = 5;
	localparam int BIT_VCXO = 4;
	localparam int BIT_REF = 1;
	localparam int BIT_HOLD = 0;
	localparam int BIT_CAL = 2;
	localparam int BIT_CMD = 7;
	localparam int BIT_EDGE = 0;
	localparam int SEL_LSB = 6;

	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic EDGE_RESET = 1'b0;

endpackage

// file: rtl/slc_sticky_flag.sv
`timescale 1ns/100ps
module slc_sticky_flag (
	input wire logic clk,
	input wire logic rstn,
	input wire logic setEvent,
	input wire logic clearReq,
	output logic flag
);
	// A set in the cycle of a clear wins so no event is lost
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag <= 1'b0;
		end else if (setEvent) begin
			flag <= 1'b1;
		end else if (clearReq) begin
			flag <= 1'b0;
		end
	end
endmodule

// file: verif/slc_host.sv
`timescale 1ns/100ps
module slc_host (
	input wire logic clk,
	input wire logic dataWire,
	output logic sclk,
	output logic csN,
	output logic hostDat,
	output logic hostOe
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		hostDat = 1'b0;
		hostOe = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Samples at the end of each low phase, which suits either readback edge
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] sh;
		sh = {rd, a, d};
		q = 8'h00;
		waitClk(1);
		csN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			hostOe = !(rd && i < 8);
			hostDat = sh[i];
			waitClk(4);
			if (i < 8) q[i] = dataWire;
			sclk = 1'b1;
			waitClk(4);
			sclk = 1'b0;
		end
		hostOe = 1'b0;
		waitClk(4);
		csN = 1'b1;
		waitClk(4);
	endtask
	task automatic startup();
		logic [7:0] q;
		xfer(1'b0, 7'h71, 8'h80, q);
		xfer(1'b0, 7'h73, 8'h80, q);
	endtask
endmodule

// file: verif/status_latch_and_general_control_test.sv
`timescale 1ns/100ps
module status_latch_and_general_control_test;
	logic clk = 1'b0, rstn = 1'b0, sclk, csN, hostDat, hostOe, dataWire;
	logic serialDataOut, serialDataOe, dividerInitPulse, synthLockRestartCmd;
	logic biasTrimCmd, readbackEdgeSelect, irqOutN;
	logic synthLockLive, vcxoLockLive, refPresentLive, holdoverLive, synthCalBusy, biasTrimDone;
	logic [3:0] inputActiveLive;
	logic [1:0] selectedInputCode;
	int nFail = 0, nChecks = 0, nInit = 0, nRelock = 0, cyc = 0;
	always #20 clk = ~clk;
	// The wire has a pull-up, so a released line reads high
	assign dataWire = serialDataOe ? serialDataOut : (hostOe ? hostDat : 1'b1);
	slc_host host (.clk(clk), .dataWire(dataWire), .sclk(sclk), .csN(csN),
		.hostDat(hostDat), .hostOe(hostOe));
	slc_status_ctrl uut (.clk(clk), .rstn(rstn), .sclk(sclk), .csN(csN),
		.serialDataIn(dataWire), .serialDataOut(serialDataOut),
		.serialDataOe(serialDataOe), .synthLockLive(synthLockLive),
		.vcxoLockLive(vcxoLockLive), .inputActiveLive(inputActiveLive),
		.selectedInputCode(selectedInputCode), .refPresentLive(refPresentLive),
		.holdoverLive(holdoverLive), .synthCalBusy(synthCalBusy),
		.biasTrimDone(biasTrimDone), .dividerInitPulse(dividerInitPulse),
		.synthLockRestartCmd(synthLockRestartCmd), .biasTrimCmd(biasTrimCmd),
		.readbackEdgeSelect(readbackEdgeSelect), .irqOutN(irqOutN));
	always @(posedge clk) begin
		cyc++;
		if (dividerInitPulse === 1'b1) nInit++;
		if (synthLockRestartCmd === 1'b1) nRelock++;
		if (cyc == 20000) begin
			nFail++;
			endSim();
		end
	end
	task automatic endSim();
		if (nFail == 0 && nChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		nChecks++;
		if (g !== e) begin
			nFail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(1'b0, a, d, q);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		host.xfer(1'b1, a, 8'h00, q);
		chk(q & m, e);
	endtask
	initial begin
		// Status inputs start healthy so that the first latches read no event
		{synthLockLive, vcxoLockLive, refPresentLive, holdoverLive} = 4'hF;
		{synthCalBusy, biasTrimDone, selectedInputCode, inputActiveLive} = 8'h0F;
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		host.waitClk(2);
		chk({7'h00, readbackEdgeSelect}, 8'h00);
		host.startup();
		chk(8'(nInit), 8'h01);
		chk({7'h00, biasTrimCmd}, 8'h01);
		rd(7'h73, 8'h81, 8'h80);
		biasTrimDone = 1'b1;
		host.waitClk(1);
		biasTrimDone = 1'b0;
		host.waitClk(2);
		chk({7'h00, biasTrimCmd}, 8'h00);
		wr(7'h73, 8'h01);
		chk({7'h00, readbackEdgeSelect}, 8'h01);
		for (int k = 0; k < 4; k++) begin
			selectedInputCode = 2'(k);
			synthLockLive = k[0];
			vcxoLockLive = k[1];
			inputActiveLive = 4'hF ^ (4'h1 << k);
			rd(7'h6D, 8'hFF, {2'(k), k[0], k[1], 4'hF ^ (4'h1 << k)});
		end
		wr(7'h73, 8'h00);
		rd(7'h73, 8'h81, 8'h00);
		for (int k = 0; k < 8; k++) begin
			{synthCalBusy, refPresentLive, holdoverLive} = 3'(k);
			rd(7'h6F, 8'h07, 8'(k));
		end
		{synthLockLive, vcxoLockLive, refPresentLive, holdoverLive} = 4'hF;
		{synthCalBusy, inputActiveLive} = 5'h0F;
		rd(7'h71, 8'hFF, 8'h00);
		rd(7'h10, 8'hFF, 8'h00);
		wr(7'h6C, 8'hFF);
		wr(7'h6E, 8'hFF);
		rd(7'h6C, 8'h3F, 8'h3F);
		rd(7'h6E, 8'h03, 8'h03);
		wr(7'h68, 8'h3F);
		wr(7'h69, 8'h03);
		rd(7'h68, 8'hFF, 8'h3F);
		rd(7'h69, 8'hFF, 8'h03);
		chk({7'h00, irqOutN}, 8'h01);
		vcxoLockLive = 1'b0;
		host.waitClk(3);
		vcxoLockLive = 1'b1;
		chk({7'h00, irqOutN}, 8'h00);
		rd(7'h6C, 8'h3F, 8'h2F);
		wr(7'h6C, 8'h10);
		chk({7'h00, irqOutN}, 8'h01);
		synthLockLive = 1'b0;
		host.waitClk(3);
		synthLockLive = 1'b1;
		rd(7'h6C, 8'h3F, 8'h1F);
		wr(7'h6C, 8'h20);
		for (int n = 0; n < 4; n++) begin
			inputActiveLive[n] = 1'b0;
			host.waitClk(3);
			inputActiveLive[n] = 1'b1;
			chk({7'h00, irqOutN}, 8'h00);
			rd(7'h6C, 8'h3F, 8'h3F & ~(8'h01 << n));
			wr(7'h6C, 8'h01 << n);
			chk({7'h00, irqOutN}, 8'h01);
		end
		holdoverLive = 1'b0;
		host.waitClk(3);
		holdoverLive = 1'b1;
		rd(7'h6E, 8'h03, 8'h02);
		wr(7'h6E, 8'h01);
		rd(7'h6E, 8'h03, 8'h03);
		chk({7'h00, irqOutN}, 8'h01);
		refPresentLive = 1'b0;
		host.waitClk(3);
		refPresentLive = 1'b1;
		chk({7'h00, irqOutN}, 8'h00);
		rd(7'h6E, 8'h03, 8'h01);
		wr(7'h6E, 8'h02);
		chk({7'h00, irqOutN}, 8'h01);
		wr(7'h72, 8'h80);
		chk(8'(nRelock), 8'h01);
		rd(7'h72, 8'hFF, 8'h00);
		wr(7'h68, 8'h00);
		vcxoLockLive = 1'b0;
		host.waitClk(3);
		vcxoLockLive = 1'b1;
		host.waitClk(2);
		chk({7'h00, irqOutN}, 8'h01);
		// Enabling a latch that is already set raises the interrupt at once
		wr(7'h73, 8'h01);
		wr(7'h68, 8'h10);
		chk({7'h00, irqOutN}, 8'h00);
		// Mid-run reset must drop the edge select, enables and latches
		rstn = 1'b0;
		host.waitClk(2);
		chk({6'h00, readbackEdgeSelect, irqOutN}, 8'h01);
		rstn = 1'b1;
		host.waitClk(2);
		rd(7'h68, 8'hFF, 8'h00);
		rd(7'h6C, 8'h3F, 8'h3F);
		endSim();
	end
endmodule
